// File: core/ecdio_pkg.sv
// Constants, types and helpers for the card detect and I/O window offset register block
// ============================================================================
// ============================================================================
package ecdio_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // ==========================================================================
  // Register offsets within socket space
  localparam logic [ADDR_W-1:0] OFF_CDGC    = 12'h816;
  localparam logic [ADDR_W-1:0] OFF_IOW0_HI = 12'h837;
  localparam logic [ADDR_W-1:0] OFF_IOW1_HI = 12'h839;
  localparam logic [ADDR_W-1:0] OFF_CSC     = 12'h804;

  // ==========================================================================
  // Field positions
  localparam int BIT_SENSE2 = 7;
  localparam int BIT_SENSE1 = 6;
  localparam int BIT_SOFT   = 5;
  localparam int BIT_WAKE   = 4;
  localparam int BIT_RMRST  = 1;
  localparam int BIT_CSC_CD = 3;

  // ==========================================================================
  // Reset values and masks
  localparam logic [DATA_W-1:0] IOW_HI_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CDGC_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] CDGC_WMASK   = 8'h12;
  localparam logic [DATA_W-1:0] CDGC_ZMASK   = 8'h2D;
  localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;
  localparam logic [1:0]        CD_ABSENT    = 2'h3;
  localparam logic [1:0]        CD_INSERTED  = 2'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } ecdio_req_t;

  typedef struct packed {
    logic cd1_n;
    logic cd2_n;
    logic sense1_level;
    logic sense2_level;
  } ecdio_pins_t;

  typedef enum logic [1:0] {
    WAKE_IDLE = 2'b01,
    WAKE_LOW  = 2'b10
  } ecdio_wake_t;

  // Byte merge under a writable-bit mask
  function automatic logic [DATA_W-1:0] ecdio_merge(input logic [DATA_W-1:0] old_val,
                                                    input logic [DATA_W-1:0] new_val,
                                                    input logic [DATA_W-1:0] mask);
    return (old_val & ~mask) | (new_val & mask);
  endfunction

endpackage

// File: core/ecdio_detect.sv
// Card detect pin change and removal event detector
`timescale 1ns/100ps
module ecdio_detect
  import ecdio_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  input  wire logic  cd1_n_in,
  input  wire logic  cd2_n_in,
  output logic       pin_change_out,
  output logic       insert_change_out,
  output logic       removal_out
);

  logic [1:0] prev_cd;
  logic       primed;
  logic [1:0] next_prev_cd;
  logic       next_primed;
  logic [1:0] cur_cd;

  assign cur_cd = {cd2_n_in, cd1_n_in};

  // ==========================================================================
  // Previous pin state
  // The first cycle after reset only captures the pins, so a card sitting in
  // the slot at reset does not look like an insertion.
  always_comb begin
    next_prev_cd = cur_cd;
    next_primed  = 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prev_cd <= CD_ABSENT;
      primed  <= 1'b0;
    end else begin
      prev_cd <= next_prev_cd;
      primed  <= next_primed;
    end
  end

  // ==========================================================================
  // Events
  assign pin_change_out    = primed && (cur_cd != prev_cd);
  assign insert_change_out = primed && ((cur_cd == CD_INSERTED) != (prev_cd == CD_INSERTED));
  assign removal_out       = primed && (prev_cd == CD_INSERTED) && (cur_cd != CD_INSERTED);

  a_removal_event : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(primed) && $past(cur_cd) == CD_INSERTED && cur_cd != CD_INSERTED |-> removal_out && insert_change_out)
    else $error("Removal not flagged when the detect pins left the inserted state");

endmodule

// File: core/ecdio_regs.sv
// Card detect, general control and I/O window offset high byte registers of one socket
`timescale 1ns/100ps
module ecdio_regs
  import ecdio_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire ecdio_req_t        req_in,
  input  wire ecdio_pins_t       pins_in,
  input  wire logic              detect_csc_enable_in,
  input  wire logic              flag_clear_select_in,
  output logic [DATA_W-1:0]      rdata_out,
  output logic                   rd_ack_out,
  output logic [DATA_W-1:0]      iow0_offset_high_out,
  output logic [DATA_W-1:0]      iow1_offset_high_out,
  output logic                   detect_wake_enable_out,
  output logic                   removal_reg_reset_out,
  output logic                   csc_detect_flag_out,
  output logic                   removal_reset_out,
  output logic                   ring_indicate_output_n_out
);

  // ==========================================================================
  // Declarations
  logic [DATA_W-1:0] iow0_hi;
  logic [DATA_W-1:0] iow1_hi;
  logic [DATA_W-1:0] cdgc;
  logic [DATA_W-1:0] next_iow0_hi;
  logic [DATA_W-1:0] next_iow1_hi;
  logic [DATA_W-1:0] next_cdgc;
  logic              csc_flag;
  logic              next_csc_flag;
  ecdio_wake_t       wake_state;
  ecdio_wake_t       next_wake_state;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic              rd_ack;
  logic              next_rd_ack;
  logic              removal_pulse;
  logic              next_removal_pulse;

  logic              pin_change;
  logic              insert_change;
  logic              removal;
  logic              wr_cdgc;
  logic              wr_iow0;
  logic              wr_iow1;
  logic              wr_csc;
  logic              rd_csc;
  logic              rd_cdgc;
  logic              wake_en;
  logic              rmrst;
  logic              removal_clear;
  logic              soft_event;
  logic              csc_set;
  logic              csc_clear;
  logic              csc_clear_evt;

  // ==========================================================================
  // Card detect events
  ecdio_detect u_detect (
    .clk_in            (clk_in),
    .rst_n_in          (rst_n_in),
    .cd1_n_in          (pins_in.cd1_n),
    .cd2_n_in          (pins_in.cd2_n),
    .pin_change_out    (pin_change),
    .insert_change_out (insert_change),
    .removal_out       (removal)
  );

  // ==========================================================================
  // Address decode
  assign wr_cdgc = req_in.wr && (req_in.addr == OFF_CDGC);
  assign wr_iow0 = req_in.wr && (req_in.addr == OFF_IOW0_HI);
  assign wr_iow1 = req_in.wr && (req_in.addr == OFF_IOW1_HI);
  assign wr_csc  = req_in.wr && (req_in.addr == OFF_CSC);
  assign rd_csc  = req_in.rd && (req_in.addr == OFF_CSC);
  assign rd_cdgc = req_in.rd && (req_in.addr == OFF_CDGC);

  assign wake_en = cdgc[BIT_WAKE];
  assign rmrst   = cdgc[BIT_RMRST];

  // Removal reset beats a write that lands in the same cycle
  assign removal_clear = removal && rmrst;

  // ==========================================================================
  // I/O window offset high bytes
  always_comb begin
    next_iow0_hi = iow0_hi;
    next_iow1_hi = iow1_hi;
    if (removal_clear) begin
      next_iow0_hi = IOW_HI_RESET;
      next_iow1_hi = IOW_HI_RESET;
    end else begin
      if (wr_iow0) begin
        next_iow0_hi = req_in.wdata;
      end
      if (wr_iow1) begin
        next_iow1_hi = req_in.wdata;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      iow0_hi <= IOW_HI_RESET;
      iow1_hi <= IOW_HI_RESET;
    end else begin
      iow0_hi <= next_iow0_hi;
      iow1_hi <= next_iow1_hi;
    end
  end

  // ==========================================================================
  // Card detect and general control
  // Only the wake enable and removal-reset bits are stored; sense bits are
  // live, the soft event bit is a strobe, and the rest are constant zero.
  always_comb begin
    next_cdgc = cdgc;
    if (removal_clear) begin
      next_cdgc = CDGC_RESET;
    end else if (wr_cdgc) begin
      next_cdgc = ecdio_merge(cdgc, req_in.wdata, CDGC_WMASK);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cdgc <= CDGC_RESET;
    end else begin
      cdgc <= next_cdgc;
    end
  end

  // ==========================================================================
  // Card-detect status change flag
  assign soft_event = wr_cdgc && req_in.wdata[BIT_SOFT] && detect_csc_enable_in;
  assign csc_set    = insert_change || soft_event;
  // Clear mode: read of the flag register, or write of 1 when selected
  assign csc_clear  = flag_clear_select_in ? (wr_csc && req_in.wdata[BIT_CSC_CD]) : rd_csc;
  // A new event in the clearing cycle keeps the flag set
  assign csc_clear_evt = csc_flag && csc_clear && !csc_set;

  always_comb begin
    next_csc_flag = csc_flag;
    if (csc_set) begin
      next_csc_flag = 1'b1;
    end else if (csc_clear) begin
      next_csc_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      csc_flag <= 1'b0;
    end else begin
      csc_flag <= next_csc_flag;
    end
  end

  // ==========================================================================
  // Ring indicate wake machine
  // A wake request in the same cycle as the clear keeps the output low.
  always_comb begin
    next_wake_state = wake_state;
    case (wake_state)
      WAKE_IDLE: begin
        if (wake_en && pin_change) begin
          next_wake_state = WAKE_LOW;
        end
      end
      WAKE_LOW: begin
        if (csc_clear_evt && !(wake_en && pin_change)) begin
          next_wake_state = WAKE_IDLE;
        end
      end
      default: begin
        next_wake_state = WAKE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_state <= WAKE_IDLE;
    end else begin
      wake_state <= next_wake_state;
    end
  end

  // ==========================================================================
  // Read path and removal pulse
  // Read data are one cycle late; reading the flag register shows the flag
  // as it stood before a read-clear.
  always_comb begin
    next_rdata         = rdata;
    next_rd_ack        = req_in.rd;
    next_removal_pulse = removal_clear;
    if (req_in.rd) begin
      case (req_in.addr)
        OFF_CDGC: begin
          next_rdata                = cdgc;
          next_rdata[BIT_SENSE2]    = pins_in.sense2_level;
          next_rdata[BIT_SENSE1]    = pins_in.sense1_level;
        end
        OFF_IOW0_HI: begin
          next_rdata = iow0_hi;
        end
        OFF_IOW1_HI: begin
          next_rdata = iow1_hi;
        end
        OFF_CSC: begin
          next_rdata             = ZERO_BYTE;
          next_rdata[BIT_CSC_CD] = csc_flag;
        end
        default: begin
          next_rdata = ZERO_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata         <= ZERO_BYTE;
      rd_ack        <= 1'b0;
      removal_pulse <= 1'b0;
    end else begin
      rdata         <= next_rdata;
      rd_ack        <= next_rd_ack;
      removal_pulse <= next_removal_pulse;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata_out                  = rdata;
  assign rd_ack_out                 = rd_ack;
  assign iow0_offset_high_out       = iow0_hi;
  assign iow1_offset_high_out       = iow1_hi;
  assign detect_wake_enable_out     = wake_en;
  assign removal_reg_reset_out      = rmrst;
  assign csc_detect_flag_out        = csc_flag;
  assign removal_reset_out          = removal_pulse;
  assign ring_indicate_output_n_out = (wake_state != WAKE_LOW);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_wake_start;
    wake_en && pin_change;
  endsequence

  sequence s_wake_hold;
    !ring_indicate_output_n_out && !csc_clear_evt;
  endsequence

  a_iow_reset_zero : assert property (disable iff (1'b0)
    !rst_n_in |=> iow0_offset_high_out == IOW_HI_RESET && iow1_offset_high_out == IOW_HI_RESET)
    else $error("I/O window offset high bytes not zero after reset");

  a_iow_write_data : assert property (
    wr_iow1 && !removal_clear |=> iow1_offset_high_out == $past(req_in.wdata))
    else $error("I/O window 1 offset high byte did not take the written value");

  a_iow_read_back : assert property (
    req_in.rd && req_in.addr == OFF_IOW0_HI |=> rd_ack_out && rdata_out == $past(iow0_hi))
    else $error("I/O window 0 offset high byte read back wrong");

  a_sense_live_read : assert property (
    rd_cdgc |=> rdata_out[BIT_SENSE2] == $past(pins_in.sense2_level)
             && rdata_out[BIT_SENSE1] == $past(pins_in.sense1_level))
    else $error("Sense pin levels not reported live");

  a_cdgc_zero_bits : assert property (
    rd_cdgc |=> (rdata_out & CDGC_ZMASK) == ZERO_BYTE)
    else $error("Write-only or reserved control bits read nonzero");

  a_soft_event_sets : assert property (
    wr_cdgc && req_in.wdata[BIT_SOFT] && detect_csc_enable_in |=> csc_detect_flag_out)
    else $error("Soft detect event did not raise the status change flag");

  a_soft_event_ignored : assert property (
    wr_cdgc && !detect_csc_enable_in && !insert_change && !csc_flag |=> !csc_detect_flag_out)
    else $error("Soft detect event acted while its enable was clear");

  a_wake_assert : assert property (
    s_wake_start |=> !ring_indicate_output_n_out [*2] or (!ring_indicate_output_n_out ##1 1'b1))
    else $error("Ring output not driven low on a detect change");

  a_wake_hold_low : assert property (
    s_wake_hold |=> !ring_indicate_output_n_out)
    else $error("Ring output released before the detect flag was cleared");

  a_wake_disabled : assert property (
    ring_indicate_output_n_out && !wake_en |=> ring_indicate_output_n_out)
    else $error("Ring output moved while wake enable was clear");

  a_removal_reset : assert property (
    removal && rmrst |=> iow0_offset_high_out == IOW_HI_RESET && !detect_wake_enable_out
                      && removal_reset_out ##1 !removal_reset_out || removal)
    else $error("Removal with reset enabled did not restore the registers");

  a_removal_keeps : assert property (
    removal && !rmrst && !wr_iow0 |=> $stable(iow0_offset_high_out))
    else $error("Removal changed registers with reset disabled");

  a_cdgc_write_mask : assert property (
    wr_cdgc && !removal_clear |=> cdgc == ecdio_merge($past(cdgc), $past(req_in.wdata), CDGC_WMASK))
    else $error("Reserved control bits took a write");

  a_clear_on_read : assert property (
    csc_flag && !flag_clear_select_in && rd_csc && !csc_set |=> !csc_detect_flag_out)
    else $error("Flag not cleared by a read in read-clear mode");

  a_clear_write_mode : assert property (
    csc_flag && flag_clear_select_in && !wr_csc |=> csc_detect_flag_out)
    else $error("Flag cleared without a write of 1 in write-clear mode");

  a_removal_flags : assert property (
    removal |=> csc_detect_flag_out)
    else $error("Card removal did not raise the detect status change flag");

endmodule

// File: dv/ecdio_slot_model.sv
// Card slot model: detect pins with pull-ups and voltage-sense levels
`timescale 1ns/100ps
module ecdio_slot_model
  import ecdio_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       present_in,
  input  wire logic       lift1_in,
  input  wire logic [1:0] vs_in,
  output ecdio_pins_t     pins_out
);
  // ==========================================================================
  // Pin levels
  // Released detect pins float to their pull-up, so an empty slot reads both high
  initial begin
    pins_out = '{cd1_n: 1'b1, cd2_n: 1'b1, sense1_level: 1'b0, sense2_level: 1'b0};
  end

  // Pins move just after an edge, like a slot that is synchronous to the host clock
  always @(posedge clk_in) begin
    pins_out.cd1_n        <= ~present_in | lift1_in;
    pins_out.cd2_n        <= ~present_in;
    pins_out.sense1_level <= vs_in[0];
    pins_out.sense2_level <= vs_in[1];
  end
endmodule

// File: dv/tb.sv
// Self-checking bench for the card detect and I/O window offset register block
`timescale 1ns/100ps
module tb;
  import ecdio_pkg::*;

  logic              clk_in;
  logic              rst_n_in;
  ecdio_req_t        req_in;
  ecdio_pins_t       pins;
  logic              detect_csc_enable_in;
  logic              flag_clear_select_in;
  logic [DATA_W-1:0] rdata_out;
  logic              rd_ack_out;
  logic [DATA_W-1:0] iow0_offset_high_out;
  logic [DATA_W-1:0] iow1_offset_high_out;
  logic              detect_wake_enable_out;
  logic              removal_reg_reset_out;
  logic              csc_detect_flag_out;
  logic              removal_reset_out;
  logic              ring_indicate_output_n_out;
  logic              present;
  logic              lift1;
  logic [1:0]        vs;
  logic [DATA_W-1:0] rv;
  int                n_errors;
  int                n_checks;
  int                pulses;

  ecdio_slot_model slot (
    .clk_in     (clk_in),
    .present_in (present),
    .lift1_in   (lift1),
    .vs_in      (vs),
    .pins_out   (pins)
  );

  ecdio_regs dut (
    .clk_in                     (clk_in),
    .rst_n_in                   (rst_n_in),
    .req_in                     (req_in),
    .pins_in                    (pins),
    .detect_csc_enable_in       (detect_csc_enable_in),
    .flag_clear_select_in       (flag_clear_select_in),
    .rdata_out                  (rdata_out),
    .rd_ack_out                 (rd_ack_out),
    .iow0_offset_high_out       (iow0_offset_high_out),
    .iow1_offset_high_out       (iow1_offset_high_out),
    .detect_wake_enable_out     (detect_wake_enable_out),
    .removal_reg_reset_out      (removal_reg_reset_out),
    .csc_detect_flag_out        (csc_detect_flag_out),
    .removal_reset_out          (removal_reset_out),
    .ring_indicate_output_n_out (ring_indicate_output_n_out)
  );

  // ==========================================================================
  // Clock, reset values and helpers
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    req_in = '0;
    detect_csc_enable_in = 1'b0;
    flag_clear_select_in = 1'b0;
    present = 1'b0;
    lift1 = 1'b0;
    vs = 2'h2;
    n_errors = 0;
    n_checks = 0;
  end

  always #2 clk_in = ~clk_in;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    req_in <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_in);
    req_in.wr <= 1'b0;
    #1;
  endtask

  // The answer stands one cycle only, so it is taken right after the launching edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_in);
    req_in <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_in);
    req_in.rd <= 1'b0;
    #1;
    chk("rd_ack", 8'h01, {7'h00, rd_ack_out});
    d = rdata_out;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    #(4 * 4000);
    n_errors++;
    complete_run();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    cyc(2);
    rd(OFF_IOW0_HI, rv); chk("iow0 reset", 8'h00, rv);
    rd(OFF_IOW1_HI, rv); chk("iow1 reset", 8'h00, rv);
    chk("ring reset", 8'h01, {7'h00, ring_indicate_output_n_out});
    chk("wake reset", 8'h00, {7'h00, detect_wake_enable_out});
    rd(12'h800, rv); chk("unmapped", 8'h00, rv);
    $display("test reset done");

    wr(OFF_IOW0_HI, 8'hA5);
    wr(OFF_IOW1_HI, 8'h5A);
    chk("iow0 out", 8'hA5, iow0_offset_high_out);
    rd(OFF_IOW0_HI, rv); chk("iow0 rd", 8'hA5, rv);
    rd(OFF_IOW1_HI, rv); chk("iow1 rd", 8'h5A, rv);
    $display("test io windows done");

    // Soft event bit must not stick and reserved bits must stay clear
    wr(OFF_CDGC, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      vs <= i[1:0];
      cyc(3);
      rd(OFF_CDGC, rv); chk("cdgc", {i[1], i[0], 6'h12}, rv);
    end
    wr(OFF_CDGC, 8'h00);
    $display("test control done");

    wr(OFF_CDGC, 8'h20); cyc(1);
    chk("soft off", 8'h00, {7'h00, csc_detect_flag_out});
    @(posedge clk_in);
    detect_csc_enable_in <= 1'b1;
    wr(OFF_CDGC, 8'h20); cyc(1);
    chk("soft on", 8'h01, {7'h00, csc_detect_flag_out});
    rd(OFF_CSC, rv); cyc(1);
    chk("csc pre", 8'h08, rv & 8'h08);
    chk("rd clear", 8'h00, {7'h00, csc_detect_flag_out});
    @(posedge clk_in);
    flag_clear_select_in <= 1'b1;
    wr(OFF_CDGC, 8'h20); cyc(1);
    rd(OFF_CSC, rv); cyc(1);
    chk("rd kept", 8'h01, {7'h00, csc_detect_flag_out});
    wr(OFF_CSC, 8'h08); cyc(1);
    chk("wr clear", 8'h00, {7'h00, csc_detect_flag_out});
    @(posedge clk_in);
    flag_clear_select_in <= 1'b0;
    $display("test soft event done");

    present <= 1'b1;
    cyc(4);
    chk("insert flag", 8'h01, {7'h00, csc_detect_flag_out});
    chk("ring no wake", 8'h01, {7'h00, ring_indicate_output_n_out});
    rd(OFF_CSC, rv); cyc(1);
    wr(OFF_CDGC, 8'h10);
    chk("wake out", 8'h01, {7'h00, detect_wake_enable_out});
    @(posedge clk_in);
    lift1 <= 1'b1;
    cyc(4);
    chk("ring low", 8'h00, {7'h00, ring_indicate_output_n_out});
    chk("removal flag", 8'h01, {7'h00, csc_detect_flag_out});
    chk("iow0 kept", 8'hA5, iow0_offset_high_out);
    wr(OFF_CDGC, 8'h00); cyc(2);
    chk("ring held", 8'h00, {7'h00, ring_indicate_output_n_out});
    rd(OFF_CSC, rv); cyc(2);
    chk("ring free", 8'h01, {7'h00, ring_indicate_output_n_out});
    $display("test wake done");

    @(posedge clk_in);
    lift1 <= 1'b0;
    cyc(4);
    rd(OFF_CSC, rv); cyc(1);
    wr(OFF_CDGC, 8'h02);
    chk("rmrst out", 8'h01, {7'h00, removal_reg_reset_out});
    pulses = 0;
    @(posedge clk_in);
    lift1 <= 1'b1;
    repeat (6) begin
      cyc(1);
      if (removal_reset_out === 1'b1) pulses++;
    end
    chk("rst pulses", 8'h01, pulses[7:0]);
    chk("iow0 clr", 8'h00, iow0_offset_high_out);
    chk("iow1 clr", 8'h00, iow1_offset_high_out);
    chk("rmrst clr", 8'h00, {7'h00, removal_reg_reset_out});
    chk("rm flag", 8'h01, {7'h00, csc_detect_flag_out});
    $display("test removal reset done");
    complete_run();
  end
endmodule
